// ### hdl/abar_bank.sv
// Register bank where each non-exempt base register has clear, set and toggle aliases
`timescale 1ns/10ps
module abar_bank
#(
	parameter int NUM_REGS = abar_pkg::ABAR_NUM_REGS,
	parameter int ADDR_W = abar_pkg::ABAR_ADDR_W,
	// Bit i set: register i is exempt and has no aliases
	parameter logic [NUM_REGS-1:0] EXEMPT_MASK = '0,
	parameter logic [31:0] IMPL_MASK = 32'hFFFF_FFFF
)
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [abar_pkg::ABAR_DATA_W-1:0] wdata_i,
	input wire logic [3:0] byte_en_i,
	output logic [abar_pkg::ABAR_DATA_W-1:0] rdata_o,
	output logic rvalid_o,
	output logic err_o,
	output logic [NUM_REGS*abar_pkg::ABAR_DATA_W-1:0] regs_o
);
	import abar_pkg::*;

	// Elaboration checks; the decode assumes whole 16-byte slots
	if (NUM_REGS < 1)
	begin : g_chk_regs
		$error("abar_bank: NUM_REGS must be at least one");
	end
	if (ADDR_W <= ABAR_SLOT_LSB || ADDR_W > 30)
	begin : g_chk_addr
		$error("abar_bank: ADDR_W leaves no room for a register index");
	end
	else if ((NUM_REGS << ABAR_SLOT_LSB) > (1 << ADDR_W))
	begin : g_chk_fit
		$error("abar_bank: NUM_REGS does not fit the address space");
	end
	// Byte strobes are laid out as one lane per eight data bits
	if (ABAR_DATA_W != 8 * $bits(byte_en_i))
	begin : g_chk_lanes
		$error("abar_bank: data width does not match the byte strobes");
	end
	// Alias offsets must be word aligned inside one slot
	if (ABAR_OFS_CLR[1:0] != 2'h0 || ABAR_OFS_SET[1:0] != 2'h0
		|| ABAR_OFS_TGL[1:0] != 2'h0)
	begin : g_chk_ofs
		$error("abar_bank: alias offsets must be word aligned");
	end

	localparam int IDX_W = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

	logic [3:0] ofs;
	logic [ADDR_W-ABAR_SLOT_LSB-1:0] slot;
	logic [IDX_W-1:0] idx;
	logic slot_ok;
	logic is_alias;
	logic hit;
	logic ofs_ok;
	logic alias_blocked;
	logic rd_base;
	logic acc_bad;
	logic [NUM_REGS-1:0] reg_wr;
	logic [ABAR_DATA_W-1:0] base_pick;
	abar_op_t op;
	logic [ABAR_DATA_W-1:0] lane_mask;
	logic [ABAR_DATA_W-1:0] cell_val [NUM_REGS];
	logic [ABAR_DATA_W-1:0] next_rdata;

	assign ofs = addr_i[ABAR_SLOT_LSB-1:0];
	assign slot = addr_i[ADDR_W-1:ABAR_SLOT_LSB];
	assign slot_ok = (32'(slot) < NUM_REGS);
	assign idx = slot_ok ? IDX_W'(slot) : '0;
	assign is_alias = (ofs != ABAR_OFS_BASE);

	// Decode the word offset inside a slot into the operation
	always_comb
	begin
		op = ABAR_OP_WRITE;
		case (ofs)
			ABAR_OFS_BASE:
				op = ABAR_OP_WRITE;
			ABAR_OFS_CLR:
				op = ABAR_OP_CLEAR;
			ABAR_OFS_SET:
				op = ABAR_OP_SET;
			ABAR_OFS_TGL:
				op = ABAR_OP_TOGGLE;
			default:
				op = ABAR_OP_WRITE;
		endcase
	end

	// Only the four word offsets of a slot are mapped
	assign ofs_ok = (ofs == ABAR_OFS_BASE) || (ofs == ABAR_OFS_CLR)
		|| (ofs == ABAR_OFS_SET) || (ofs == ABAR_OFS_TGL);
	// Exempt registers answer on the base word alone
	assign alias_blocked = is_alias && EXEMPT_MASK[idx];
	assign hit = slot_ok && ofs_ok && !alias_blocked;
	assign rd_base = hit && !is_alias;
	// Any strobe that misses the map is dropped and reported
	assign acc_bad = (rd_en_i || wr_en_i) && !hit;

	// Each byte strobe opens its own eight bits and no others
	genvar n;
	generate
		for (n = 0; n < $bits(byte_en_i); n++)
		begin : g_lane
			assign lane_mask[8*n +: 8] = {8{byte_en_i[n]}};
		end
	endgenerate

	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++)
		begin : g_reg
			// Strobe reaches only the addressed base register
			assign reg_wr[g] = wr_en_i && hit && (32'(idx) == g);
			abar_bit_cell
			#(
				.WIDTH(ABAR_DATA_W),
				.IMPL_MASK(IMPL_MASK),
				.RESET_VAL(ABAR_RESET_VALUE)
			)
			u_cell
			(
				.clock_i(clock_i),
				.sys_rst_i(sys_rst_i),
				.wr_i(reg_wr[g]),
				.op_i(op),
				.wdata_i(wdata_i),
				.lane_mask_i(lane_mask),
				.value_o(cell_val[g])
			);
			assign regs_o[g*ABAR_DATA_W +: ABAR_DATA_W] = cell_val[g];
		end
	endgenerate

	// Plain select over the implemented slots, no variable array index
	always_comb
	begin
		base_pick = '0;
		for (int r = 0; r < NUM_REGS; r++)
		begin
			if (32'(idx) == r)
				base_pick = cell_val[r];
		end
	end

	// Alias reads give a fixed filler so software cannot rely on them
	// A read in the same cycle as a write returns the old value
	always_comb
	begin
		next_rdata = ABAR_UNDEF_READ;
		if (rd_base)
			next_rdata = base_pick;
		else
			next_rdata = ABAR_UNDEF_READ;
	end

	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			rdata_o <= '0;
		else if (rd_en_i)
			rdata_o <= next_rdata;
	end

	// Every read is answered, refused ones too, so the bus never stalls
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			rvalid_o <= 1'b0;
		else
			rvalid_o <= rd_en_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			err_o <= 1'b0;
		else
			err_o <= acc_bad;
	end
endmodule

// ### hdl/abar_bit_cell.sv
// One base register with its write, clear, set and toggle update
`timescale 1ns/10ps
module abar_bit_cell
#(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] IMPL_MASK = '1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic wr_i,
	input wire abar_pkg::abar_op_t op_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [WIDTH-1:0] lane_mask_i,
	output logic [WIDTH-1:0] value_o
);
	import abar_pkg::*;

	logic [WIDTH-1:0] sel;
	logic [WIDTH-1:0] next_value;

	// Unimplemented bits and disabled lanes are never touched
	assign sel = wdata_i & lane_mask_i & IMPL_MASK;

	always_comb
	begin
		next_value = value_o;
		case (op_i)
			ABAR_OP_WRITE:
				next_value = (value_o & ~(lane_mask_i & IMPL_MASK))
					| (wdata_i & lane_mask_i & IMPL_MASK);
			ABAR_OP_CLEAR:
				next_value = value_o & ~sel;
			ABAR_OP_SET:
				next_value = value_o | sel;
			ABAR_OP_TOGGLE:
				next_value = value_o ^ sel;
			default:
				next_value = value_o;
		endcase
	end

	// Single-cycle update, no read-modify-write by software; zeros keep on clear, set and toggle
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			value_o <= RESET_VAL & IMPL_MASK;
		else if (wr_i)
			value_o <= next_value;
	end
endmodule

// ### hdl/abar_pkg.sv
// Package: alias offsets, widths and reset values for the alias register bank
package abar_pkg;
	localparam int ABAR_DATA_W = 32;
	localparam int ABAR_ADDR_W = 12;
	localparam int ABAR_NUM_REGS = 4;
	// Alias offsets from the base register word
	localparam logic [3:0] ABAR_OFS_BASE = 4'h0;
	localparam logic [3:0] ABAR_OFS_CLR = 4'h4;
	localparam logic [3:0] ABAR_OFS_SET = 4'h8;
	localparam logic [3:0] ABAR_OFS_TGL = 4'hC;
	// Each base register with its aliases takes a 16-byte slot
	localparam int ABAR_SLOT_LSB = 4;
	localparam logic [31:0] ABAR_RESET_VALUE = 32'h0000_0000;
	localparam logic [31:0] ABAR_UNDEF_READ = 32'h0000_0000;
	typedef enum logic [1:0] {
		ABAR_OP_WRITE,
		ABAR_OP_CLEAR,
		ABAR_OP_SET,
		ABAR_OP_TOGGLE
	} abar_op_t;
endpackage

// ### verification/abar_bank_assertions.sv
// Checker for alias updates, decode errors and alias reads of the bank
`timescale 1ns/10ps
module abar_bank_chk
#(
	parameter logic [3:0] EXEMPT_MASK = 4'h0
)
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [11:0] addr_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] byte_en_i,
	input wire logic [31:0] rdata_o,
	input wire logic err_o,
	input wire logic [127:0] regs_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	wire logic f0 = wr_en_i && byte_en_i == 4'hF;
	wire logic [31:0] r0 = regs_o[31:0];
	clr_op_a:
	assert property (f0 && addr_i == 12'h004 |=>
		r0 == ($past(r0) & ~$past(wdata_i))) else $error("bad clear");
	set_op_a:
	assert property (f0 && addr_i == 12'h008 |=>
		r0 == ($past(r0) | $past(wdata_i))) else $error("bad set");
	tgl_op_a:
	assert property (f0 && addr_i == 12'h00C |=>
		r0 == ($past(r0) ^ $past(wdata_i))) else $error("bad toggle");
	other_reg_a:
	assert property (wr_en_i && addr_i[11:4] == 8'h00 |=>
		$stable(regs_o[127:32])) else $error("other reg changed");
	zero_keep_a:
	assert property (wr_en_i && (byte_en_i == 4'h0 || addr_i[3:2] != 2'h0
		&& wdata_i == 32'h0000_0000) |=> $stable(regs_o)) else $error("bits moved");
	alias_rd_a:
	assert property (rd_en_i && addr_i[11:4] == 8'h00 && addr_i[3:2] != 2'h0
		&& addr_i[1:0] == 2'h0 |=> rdata_o == 32'h0000_0000) else $error("alias read");
	dec_err_a:
	assert property ((wr_en_i || rd_en_i) && addr_i[1:0] != 2'h0 |=> err_o)
		else $error("no decode error");
	exempt_a:
	assert property (wr_en_i && addr_i[11:6] == 6'h00 && EXEMPT_MASK[addr_i[5:4]]
		&& addr_i[3:0] != 4'h0 |=> err_o && $stable(regs_o)) else $error("exempt alias");
endmodule
bind abar_bank abar_bank_chk #(.EXEMPT_MASK(EXEMPT_MASK)) u_chk (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
	.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
	.byte_en_i(byte_en_i), .rdata_o(rdata_o), .err_o(err_o),
	.regs_o(regs_o));

// ### verification/abar_bank_tb_top.sv
// Bench: alias bank against a bit-level reference model
`timescale 1ns/10ps
module abar_bank_tb_top;
	logic clock_i = 0, sys_rst_i = 1, wr_en_i = 0, rd_en_i = 0, err_o;
	logic [11:0] addr_i = 12'h000;
	logic [31:0] wdata_i = 32'h0000_0000, rdata_o;
	logic [3:0] byte_en_i = 4'h0;
	logic [127:0] regs_o, m = '0;
	logic rvalid_o;
	int bad_count = 0, samples_checked = 0, seed = 32'h61c0, cyc = 0;
	abar_bank #(.EXEMPT_MASK(4'h8)) u_abar_bank (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
		.rd_en_i(rd_en_i), .wdata_i(wdata_i), .byte_en_i(byte_en_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .err_o(err_o), .regs_o(regs_o));
	initial forever #12.5 clock_i = ~clock_i;
	task summarize();
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(string n, logic [127:0] e, logic [127:0] g);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task acc(logic w, logic r, logic [11:0] a, logic [31:0] d, logic [3:0] b);
		logic [31:0] v, l, k, o;
		logic ok;
		v = m[a[5:4]*32+:32];
		l = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		k = d & l;
		ok = a[11:6] == 0 && a[1:0] == 0 && !(a[5:4] == 3 && a[3:2] != 0);
		case (a[3:2])
			0: o = v & ~l | k;
			1: o = v & ~k;
			2: o = v | k;
			default: o = v ^ k;
		endcase
		@(posedge clock_i);
		{wr_en_i, rd_en_i, addr_i, wdata_i, byte_en_i} <= {w, r, a, d, b};
		@(posedge clock_i);
		{wr_en_i, rd_en_i} <= 2'h0;
		#1;
		if (w && ok)
			m[a[5:4]*32+:32] = o;
		chk("regs", m, regs_o);
		chk("err", !ok && (w || r), err_o);
		chk("rvalid", r, rvalid_o);
		if (r && ok)
			chk("rdata", a[3:2] != 0 ? 0 : v, rdata_o);
	endtask
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			summarize();
		end
	end
	initial
	begin
		repeat (10) @(posedge clock_i);
		sys_rst_i <= 0;
		for (int i = 0; i < 16; i++)
			acc(1, 1, {6'h00, i[3:2], i[1:0], 2'h0},
				32'hA5A5_0F0F, 4'hF);
		acc(1, 0, 12'h00C, 32'h0000_0000, 4'hF);
		acc(1, 0, 12'h008, 32'hFFFF_FFFF, 4'h0);
		repeat (400)
			acc(1'($random(seed)), 1'($random(seed)),
				12'($random(seed)) & 12'h07D, $random(seed),
				4'($random(seed)));
		summarize();
	end
endmodule
